//--- rrs_core.sv
// rotate-right and set-file execution datapath with axi4-lite registers
//
// Behaviour
// - decode rotate right, opcode 0100 00da ffffffff
// - rotate right, old bit 0 into bit 7
// - d=0 result to accumulator, d=1 to file
// - accumulator destination leaves file register unchanged
// - a=0 access bank, a=1 use bank select
// - a=0, extended set, f<=95: indexed offset
// - set instruction writes all ones to file
// - carry rotate: old carry in, bit 0 out
//
// Chosen here: the address map and register access over AXI4-Lite.
`include "rrs_consts.svh"
`default_nettype none

module rrs_core #(
	parameter int BANK_W = 4,
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i
);
	import rrs_pkg::*;

	localparam int MEM_W = BANK_W + 8;
	localparam int MEM_D = 1 << MEM_W;

	// bus channel state
	logic              awready_ff;
	logic              wready_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              arready_ff;
	logic              rvalid_ff;
	logic [1:0]        rresp_ff;
	logic [31:0]       rdata_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0]       wdata_ff;
	logic [3:0]        wstrb_ff;

	// software-visible state
	logic              ext_en_ff;
	logic [15:0]       instr_ff;
	logic [7:0]        acc_ff;
	logic [BANK_W-1:0] bank_select_reg_ff;
	logic [MEM_W-1:0]  index_ff;
	logic [MEM_W-1:0]  faddr_ff;
	logic              carry_ff;
	logic              zero_ff;
	logic              neg_ff;
	logic              bad_ff;
	logic [7:0]        general_purpose_file [MEM_D];

	// execution pipeline state
	rrs_phase_t        phase_ff;
	rrs_op_t           op_ff;
	logic              dest_acc_ff;
	logic [MEM_W-1:0]  eaddr_ff;
	logic [7:0]        operand_ff;
	logic [7:0]        result_ff;
	logic              res_carry_ff;
	logic              res_neg_ff;
	logic              res_zero_ff;

	// combinational helpers
	logic              do_write;
	logic              wr_hit;
	logic              idle;
	logic [31:0]       wr_val;
	rrs_op_t           nxt_op;
	logic [MEM_W-1:0]  nxt_eaddr;
	logic [7:0]        f_addr;
	logic              a_bit;
	logic              d_bit;
	logic [7:0]        alu_result;
	logic              alu_carry;
	logic              alu_neg;
	logic              alu_zero;
	logic [31:0]       rd_val;
	logic              rd_hit;

	assign s_axi_awready_o = awready_ff;
	assign s_axi_wready_o  = wready_ff;
	assign s_axi_bvalid_o  = bvalid_ff;
	assign s_axi_bresp_o   = bresp_ff;
	assign s_axi_arready_o = arready_ff;
	assign s_axi_rvalid_o  = rvalid_ff;
	assign s_axi_rresp_o   = rresp_ff;
	assign s_axi_rdata_o   = rdata_ff;

	// a write goes ahead once address and data are both held
	assign do_write = ~awready_ff & ~wready_ff & ~bvalid_ff;
	assign idle     = (phase_ff == RRS_PH_IDLE);

	// apply byte strobes; only register bits that exist are kept
	always_comb begin
		wr_val = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			wr_val[i*8 +: 8] = wstrb_ff[i] ? wdata_ff[i*8 +: 8] : 8'h00;
		end
	end

	// write address decode
	always_comb begin
		case (awaddr_ff)
			`RRS_OFF_CTRL, `RRS_OFF_INSTR, `RRS_OFF_STATUS, `RRS_OFF_ACC,
			`RRS_OFF_BANK, `RRS_OFF_INDEX, `RRS_OFF_FADDR,
			`RRS_OFF_FDATA: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// write address, write data and response channels
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `RRS_RESP_OKAY;
			awaddr_ff  <= '0;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && awready_ff) begin
				awready_ff <= 1'b0;
				awaddr_ff  <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && wready_ff) begin
				wready_ff <= 1'b0;
				wdata_ff  <= s_axi_wdata_i;
				wstrb_ff  <= s_axi_wstrb_i;
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit ? `RRS_RESP_OKAY : `RRS_RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready_i) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// read mux; the file window reads the byte under the file pointer
	always_comb begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			`RRS_OFF_CTRL:   rd_val[`RRS_CTRL_EXT] = ext_en_ff;
			`RRS_OFF_INSTR:  rd_val[15:0] = instr_ff;
			`RRS_OFF_STATUS: begin
				rd_val[`RRS_ST_CARRY] = carry_ff;
				rd_val[`RRS_ST_ZERO]  = zero_ff;
				rd_val[`RRS_ST_NEG]   = neg_ff;
				rd_val[`RRS_ST_BAD]   = bad_ff;
				rd_val[`RRS_ST_BUSY]  = ~idle;
			end
			`RRS_OFF_ACC:    rd_val[7:0] = acc_ff;
			`RRS_OFF_BANK:   rd_val[BANK_W-1:0] = bank_select_reg_ff;
			`RRS_OFF_INDEX:  rd_val[MEM_W-1:0] = index_ff;
			`RRS_OFF_FADDR:  rd_val[MEM_W-1:0] = faddr_ff;
			`RRS_OFF_FDATA:  rd_val[7:0] = general_purpose_file[faddr_ff];
			default:         rd_hit = 1'b0;
		endcase
	end

	// read address and read data channels
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= `RRS_RESP_OKAY;
			rdata_ff   <= 32'h00000000;
		end else if (s_axi_arvalid_i && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_val;
			rresp_ff   <= rd_hit ? `RRS_RESP_OKAY : `RRS_RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready_i) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// configuration registers; these never conflict with execution
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ext_en_ff          <= 1'b0;
			bank_select_reg_ff <= '0;
			index_ff           <= '0;
			faddr_ff           <= '0;
		end else if (do_write) begin
			case (awaddr_ff)
				`RRS_OFF_CTRL:  ext_en_ff <= wr_val[`RRS_CTRL_EXT];
				`RRS_OFF_BANK:  bank_select_reg_ff <= wr_val[BANK_W-1:0];
				`RRS_OFF_INDEX: index_ff <= wr_val[MEM_W-1:0];
				`RRS_OFF_FADDR: faddr_ff <= wr_val[MEM_W-1:0];
				default: ;
			endcase
		end
	end

	// instruction fields of the held word
	assign f_addr = instr_ff[7:0];
	assign a_bit  = instr_ff[`RRS_A_BIT];
	assign d_bit  = instr_ff[`RRS_D_BIT];

	// opcode recognition
	always_comb begin
		if (instr_ff[15:10] == `RRS_OPC_ROT_NC) begin
			nxt_op = RRS_OP_ROT_NC;
		end else if (instr_ff[15:10] == `RRS_OPC_ROT_C) begin
			nxt_op = RRS_OP_ROT_C;
		end else if (instr_ff[15:9] == `RRS_OPC_SET) begin
			nxt_op = RRS_OP_SET;
		end else begin
			nxt_op = RRS_OP_NONE;
		end
	end

	// effective file address; indexed mode only covers offsets 0 to 95, added to index_ff
	always_comb begin
		if (a_bit) begin
			nxt_eaddr = {bank_select_reg_ff, f_addr};
		end else if (ext_en_ff && f_addr <= `RRS_IDX_LIMIT) begin
			nxt_eaddr = index_ff + MEM_W'(f_addr);
		end else if (f_addr < `RRS_ACC_SPLIT) begin
			nxt_eaddr = {{BANK_W{1'b0}}, f_addr};
		end else begin
			nxt_eaddr = {{BANK_W{1'b1}}, f_addr};
		end
	end

	rrs_alu #(
		.DATA_W    (8)
	) u_alu (
		.op_i      (op_ff),
		.operand_i (operand_ff),
		.carry_i   (carry_ff),
		.result_o  (alu_result),
		.carry_o   (alu_carry),
		.neg_o     (alu_neg),
		.zero_o    (alu_zero)
	);

	// phase sequencer: a new word is only taken while idle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			phase_ff <= RRS_PH_IDLE;
			instr_ff <= `RRS_RST_INSTR;
		end else begin
			case (phase_ff)
				RRS_PH_IDLE: begin
					if (do_write && awaddr_ff == `RRS_OFF_INSTR) begin
						instr_ff <= wr_val[15:0];
						phase_ff <= RRS_PH_Q1;
					end
				end
				RRS_PH_Q1: phase_ff <= RRS_PH_Q2;
				RRS_PH_Q2: phase_ff <= RRS_PH_Q3;
				RRS_PH_Q3: phase_ff <= RRS_PH_Q4;
				RRS_PH_Q4: phase_ff <= RRS_PH_IDLE;
				default:   phase_ff <= RRS_PH_IDLE;
			endcase
		end
	end

	// decode, read and process stages
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			op_ff        <= RRS_OP_NONE;
			dest_acc_ff  <= 1'b0;
			eaddr_ff     <= '0;
			operand_ff   <= `RRS_RST_BYTE;
			result_ff    <= `RRS_RST_BYTE;
			res_carry_ff <= 1'b0;
			res_neg_ff   <= 1'b0;
			res_zero_ff  <= 1'b0;
		end else begin
			if (phase_ff == RRS_PH_Q1) begin
				op_ff       <= nxt_op;
				// the set instruction has no destination bit
				dest_acc_ff <= (nxt_op != RRS_OP_SET) && !d_bit;
				eaddr_ff    <= nxt_eaddr;
			end
			if (phase_ff == RRS_PH_Q2) begin
				operand_ff <= general_purpose_file[eaddr_ff];
			end
			if (phase_ff == RRS_PH_Q3) begin
				result_ff    <= alu_result;
				res_carry_ff <= alu_carry;
				res_neg_ff   <= alu_neg;
				res_zero_ff  <= alu_zero;
			end
		end
	end

	// unrecognised words run all four phases and only set the bad flag
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			bad_ff <= 1'b0;
		end else if (phase_ff == RRS_PH_Q1) begin
			bad_ff <= (nxt_op == RRS_OP_NONE);
		end
	end

	// file write-back in q4 has priority; software writes only while idle
	always_ff @(posedge sys_clk_i) begin
		if (phase_ff == RRS_PH_Q4 && op_ff != RRS_OP_NONE && !dest_acc_ff) begin
			general_purpose_file[eaddr_ff] <= result_ff;
		end else if (do_write && idle && awaddr_ff == `RRS_OFF_FDATA &&
				wstrb_ff[0]) begin
			general_purpose_file[faddr_ff] <= wr_val[7:0];
		end
	end

	// accumulator
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			acc_ff <= `RRS_RST_BYTE;
		end else if (phase_ff == RRS_PH_Q4 && op_ff != RRS_OP_NONE &&
				dest_acc_ff) begin
			acc_ff <= result_ff;
		end else if (do_write && idle && awaddr_ff == `RRS_OFF_ACC) begin
			acc_ff <= wr_val[7:0];
		end
	end

	// status flags: set leaves them, carry only moves on the carry rotate
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			carry_ff <= 1'b0;
			zero_ff  <= 1'b0;
			neg_ff   <= 1'b0;
		end else if (phase_ff == RRS_PH_Q4) begin
			if (op_ff == RRS_OP_ROT_NC || op_ff == RRS_OP_ROT_C) begin
				zero_ff <= res_zero_ff;
				neg_ff  <= res_neg_ff;
			end
			if (op_ff == RRS_OP_ROT_C) begin
				carry_ff <= res_carry_ff;
			end
		end else if (do_write && idle && awaddr_ff == `RRS_OFF_STATUS) begin
			carry_ff <= wr_val[`RRS_ST_CARRY];
			zero_ff  <= wr_val[`RRS_ST_ZERO];
			neg_ff   <= wr_val[`RRS_ST_NEG];
		end
	end

endmodule // rrs_core

`default_nettype wire

//--- rrs_consts.svh
// constants for the rotate-right and set-file datapath
`ifndef RRS_CONSTS_SVH
`define RRS_CONSTS_SVH

// register byte offsets on the axi4-lite bus
`define RRS_OFF_CTRL    8'h00
`define RRS_OFF_INSTR   8'h04
`define RRS_OFF_STATUS  8'h08
`define RRS_OFF_ACC     8'h0C
`define RRS_OFF_BANK    8'h10
`define RRS_OFF_INDEX   8'h14
`define RRS_OFF_FADDR   8'h18
`define RRS_OFF_FDATA   8'h1C

// field positions
`define RRS_CTRL_EXT    0
`define RRS_ST_CARRY    0
`define RRS_ST_ZERO     1
`define RRS_ST_NEG      2
`define RRS_ST_BAD      3
`define RRS_ST_BUSY     4
`define RRS_D_BIT       9
`define RRS_A_BIT       8

// opcode patterns
`define RRS_OPC_ROT_NC  6'h10
`define RRS_OPC_ROT_C   6'h0C
`define RRS_OPC_SET     7'h34

// addressing limits
`define RRS_IDX_LIMIT   8'h5F
`define RRS_ACC_SPLIT   8'h60

// reset values and bus answers
`define RRS_RST_BYTE    8'h00
`define RRS_RST_INSTR   16'h0000
`define RRS_RESP_OKAY   2'h0
`define RRS_RESP_SLVERR 2'h2

`endif

//--- rrs_pkg.sv
// types shared by the rotate-right and set-file datapath
`default_nettype none

package rrs_pkg;

	// operation recognised in the decode phase
	typedef enum logic [1:0] {
		RRS_OP_NONE   = 2'b00,
		RRS_OP_ROT_NC = 2'b01,
		RRS_OP_ROT_C  = 2'b10,
		RRS_OP_SET    = 2'b11
	} rrs_op_t;

	// idle and the four phases of one instruction cycle
	typedef enum logic [2:0] {
		RRS_PH_IDLE = 3'b000,
		RRS_PH_Q1   = 3'b001,
		RRS_PH_Q2   = 3'b010,
		RRS_PH_Q3   = 3'b011,
		RRS_PH_Q4   = 3'b100
	} rrs_phase_t;

endpackage : rrs_pkg

`default_nettype wire

//--- rrs_alu.sv
// combinational rotate and set unit with flag outputs
`default_nettype none

module rrs_alu #(
	parameter int DATA_W = 8
) (
	input  wire rrs_pkg::rrs_op_t    op_i,
	input  wire logic [DATA_W-1:0]   operand_i,
	input  wire logic                carry_i,
	output logic      [DATA_W-1:0]   result_o,
	output logic                     carry_o,
	output logic                     neg_o,
	output logic                     zero_o
);
	import rrs_pkg::*;

	// result and carry; unknown ops pass the operand through untouched
	always_comb begin
		result_o = operand_i;
		carry_o  = carry_i;
		case (op_i)
			RRS_OP_ROT_NC: begin
				result_o = {operand_i[0], operand_i[DATA_W-1:1]};
			end
			RRS_OP_ROT_C: begin
				result_o = {carry_i, operand_i[DATA_W-1:1]};
				carry_o  = operand_i[0];
			end
			RRS_OP_SET: begin
				result_o = {DATA_W{1'b1}};
			end
			default: begin
				result_o = operand_i;
			end
		endcase
	end

	// sign and zero follow the result
	assign neg_o  = result_o[DATA_W-1];
	assign zero_o = (result_o == {DATA_W{1'b0}});

endmodule // rrs_alu

`default_nettype wire

//--- rrs_core_sva.sv
// bus handshake checker for the rotate-right and set-file datapath
`include "rrs_consts.svh"
`default_nettype none

module rrs_core_sva #(
	parameter int BANK_W = 4,
	parameter int ADDR_W = 8
) (
	input wire logic              sys_clk_i,
	input wire logic              rst_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic              s_axi_awvalid_i,
	input wire logic              s_axi_awready_o,
	input wire logic [31:0]       s_axi_wdata_i,
	input wire logic [3:0]        s_axi_wstrb_i,
	input wire logic              s_axi_wvalid_i,
	input wire logic              s_axi_wready_o,
	input wire logic [1:0]        s_axi_bresp_o,
	input wire logic              s_axi_bvalid_o,
	input wire logic              s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic              s_axi_arvalid_i,
	input wire logic              s_axi_arready_o,
	input wire logic [31:0]       s_axi_rdata_o,
	input wire logic [1:0]        s_axi_rresp_o,
	input wire logic              s_axi_rvalid_o,
	input wire logic              s_axi_rready_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// handshake shorthands keep the properties short
	wire logic aw_hs = s_axi_awvalid_i && s_axi_awready_o;
	wire logic w_hs  = s_axi_wvalid_i && s_axi_wready_o;
	wire logic b_hs  = s_axi_bvalid_o && s_axi_bready_i;
	wire logic ar_hs = s_axi_arvalid_i && s_axi_arready_o;
	wire logic r_hs  = s_axi_rvalid_o && s_axi_rready_i;

	AST_B_LAT: assert property (aw_hs && w_hs |=> !s_axi_bvalid_o ##1
		s_axi_bvalid_o) else $error("write answer not two cycles late");
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b dropped");
	AST_B_DONE: assert property (b_hs |=> !s_axi_bvalid_o &&
		s_axi_awready_o && s_axi_wready_o) else $error("b not closed");
	AST_AW_LOW: assert property (aw_hs |=> !s_axi_awready_o)
		else $error("awready high during write");
	AST_R_LAT: assert property (ar_hs |=> s_axi_rvalid_o)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("r dropped");
	AST_R_DONE: assert property (r_hs |=> !s_axi_rvalid_o &&
		s_axi_arready_o) else $error("r not closed");
	AST_R_ERR: assert property (s_axi_rvalid_o &&
		s_axi_rresp_o == `RRS_RESP_SLVERR |-> s_axi_rdata_o == 32'h0)
		else $error("error read carries data");

	// main traffic kinds
	CV_WR: cover property (b_hs && s_axi_bresp_o == `RRS_RESP_OKAY);
	CV_WERR: cover property (b_hs && s_axi_bresp_o == `RRS_RESP_SLVERR);
	CV_RD: cover property (r_hs);
endmodule // rrs_core_sva

bind rrs_core rrs_core_sva #(.BANK_W(BANK_W), .ADDR_W(ADDR_W)) u_sva (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
	.s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i));

`default_nettype wire

//--- tb.sv
// self-checking bench for the rotate-right and set-file datapath
`include "rrs_consts.svh"
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rrs_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          bad_count = 0;
	int          compares = 0;

	rrs_core DUT (
		.sys_clk_i(clk), .rst_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));

	// 100 MHz clock
	always #5 clk = ~clk;

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, e}, "bresp");
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] e,
		output logic [31:0] g);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		g = rdata;
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, e}, "rresp");
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input string m);
		logic [31:0] g;
		rd(a, `RRS_RESP_OKAY, g);
		chk(g, e, m);
	endtask

	task automatic wok(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, `RRS_RESP_OKAY);
	endtask

	// start an instruction, then poll busy under a bounded count;
	// the four phases end between the first and the second poll, so a
	// stuck or slow sequencer shows up as a wrong poll count
	task automatic exec(input logic [15:0] i);
		logic [31:0] s;
		int          n;
		wok(`RRS_OFF_INSTR, {16'h0, i});
		for (n = 0; n < 20; n++) begin
			rd(`RRS_OFF_STATUS, `RRS_RESP_OKAY, s);
			if (s[`RRS_ST_BUSY] === 1'b0) break;
		end
		chk(n, 32'h00000001, "busy polls");
	endtask

	task automatic t_rot();
		wok(`RRS_OFF_BANK, 32'h2);
		wok(`RRS_OFF_FADDR, 32'h234);
		wok(`RRS_OFF_FDATA, 32'hD7);
		exec(16'h4334);
		rchk(`RRS_OFF_FDATA, 32'hEB, "rot to file");
		// a left-rotate pattern must not be taken as a right rotate
		exec(16'h4434);
		rchk(`RRS_OFF_FDATA, 32'hEB, "left kept");
		rchk(`RRS_OFF_STATUS, 32'h0C, "bad flag");
		$display("test rot done");
	endtask

	task automatic t_acc();
		wok(`RRS_OFF_FADDR, 32'h010);
		wok(`RRS_OFF_FDATA, 32'hD7);
		wok(`RRS_OFF_ACC, 32'h0);
		exec(16'h4010);
		rchk(`RRS_OFF_ACC, 32'hEB, "rot to acc");
		rchk(`RRS_OFF_FDATA, 32'hD7, "src kept");
		rchk(`RRS_OFF_STATUS, 32'h04, "flags");
		$display("test acc done");
	endtask

	task automatic t_rrc();
		wok(`RRS_OFF_FADDR, 32'h020);
		wok(`RRS_OFF_FDATA, 32'hE6);
		wok(`RRS_OFF_STATUS, 32'h1);
		exec(16'h3020);
		rchk(`RRS_OFF_ACC, 32'hF3, "carry in");
		rchk(`RRS_OFF_STATUS, 32'h04, "carry out");
		rchk(`RRS_OFF_FDATA, 32'hE6, "src kept");
		$display("test carry done");
	endtask

	task automatic t_idx();
		wok(`RRS_OFF_CTRL, 32'h1);
		wok(`RRS_OFF_INDEX, 32'h300);
		wok(`RRS_OFF_FADDR, 32'h005);
		wok(`RRS_OFF_FDATA, 32'h11);
		wok(`RRS_OFF_FADDR, 32'hF60);
		wok(`RRS_OFF_FDATA, 32'h00);
		wok(`RRS_OFF_FADDR, 32'h305);
		wok(`RRS_OFF_FDATA, 32'h5A);
		exec(16'h6805);
		rchk(`RRS_OFF_FDATA, 32'hFF, "indexed set");
		wok(`RRS_OFF_FADDR, 32'h005);
		rchk(`RRS_OFF_FDATA, 32'h11, "direct kept");
		// first offset above the indexed range stays in the access bank
		exec(16'h6860);
		wok(`RRS_OFF_FADDR, 32'hF60);
		rchk(`RRS_OFF_FDATA, 32'hFF, "edge set");
		$display("test index done");
	endtask

	task automatic t_err();
		logic [31:0] g;
		wr(8'h20, 32'h1, `RRS_RESP_SLVERR);
		rd(8'h20, `RRS_RESP_SLVERR, g);
		chk(g, 32'h0, "unmapped data");
		$display("test unmapped done");
	endtask

	task automatic conclude();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence, reset held for 20 cycles
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_rot();
		t_acc();
		t_rrc();
		t_idx();
		t_err();
		conclude();
	end

	// watchdog well beyond the roughly 200 cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end
endmodule // tb

`default_nettype wire
